// ===== pkg/gfs_pkg.sv
// package: register map, field positions and reset values of the gate fault status bank
package gfs_pkg;

  // ==========================================================
  // register offsets
  localparam logic [5:0] GateFaultStatusLowAddr  = 6'h03;
  localparam logic [5:0] GateFaultStatusHighAddr = 6'h04;
  localparam logic [5:0] SupplyTempLinkAddr      = 6'h05;
  localparam logic [5:0] VariantIdentityAddr     = 6'h06;

  // ==========================================================
  // supply / temperature / link register bit positions
  localparam int SupplyUvBit     = 7;
  localparam int SupplyOvBit     = 6;
  localparam int ChargePumpUvBit = 5;
  localparam int OverTempWarnBit = 4;
  localparam int OverTempShdnBit = 3;
  localparam int WatchdogBit     = 2;
  localparam int SerialFrameBit  = 1;

  // ==========================================================
  // reset values and frame length
  localparam logic [7:0] StatusResetValue  = 8'h00;
  localparam logic [3:0] VariantResetField = 4'h0;
  localparam logic [4:0] FrameClockCount   = 5'h10;
  localparam logic [4:0] FrameCountMax     = 5'h1F;

  // ==========================================================
  // frame checker states
  typedef enum logic [1:0] {
    GFS_IDLE  = 2'b01,
    GFS_FRAME = 2'b10
  } gfs_frame_state_t;

endpackage : gfs_pkg

// ===== verilog/gfs_frame_checker.sv
// module: counts serial clocks in each frame and flags a count other than sixteen
module gfs_frame_checker
  import gfs_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // serial frame observation
  input  wire logic frameActive,
  input  wire logic serialClockRise,
  // result
  output logic      frameFaultPulse
);

  // ==========================================================
  // frame length counter
  gfs_frame_state_t state;
  logic [4:0]       clockCount;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state      <= GFS_IDLE;
      clockCount <= 5'h00;
    end else begin
      unique case (state)
        GFS_IDLE: begin
          clockCount <= 5'h00;
          if (frameActive) begin
            state      <= GFS_FRAME;
            clockCount <= serialClockRise ? 5'h01 : 5'h00;
          end
        end
        GFS_FRAME: begin
          // saturate so a long frame never wraps back to sixteen
          if (serialClockRise && clockCount != FrameCountMax) begin
            clockCount <= clockCount + 5'h01;
          end
          if (!frameActive) begin
            state <= GFS_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // evaluate at frame end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      frameFaultPulse <= 1'b0;
    end else begin
      frameFaultPulse <= (state == GFS_FRAME) && !frameActive
                         && (clockCount != FrameClockCount);
    end
  end

  property p_frame_len;
    @(posedge core_clk) disable iff (reset)
      (state == GFS_FRAME && !frameActive && clockCount == FrameClockCount)
      |=> !frameFaultPulse;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("fault flagged on a sixteen clock frame");
  c_bad_frame: cover property (@(posedge core_clk) disable iff (reset) frameFaultPulse);

endmodule : gfs_frame_checker

// ===== verilog/gfs_status_bank.sv
// module: read-only gate fault, supply and variant status register bank
// Functional notes
// - low gate register: bridges one to four, high side bit 7, low side bit 6 onward
// - high gate register: bridges five to eight, bit 7 high five, bit 0 low eight
// - gate fault bits are read only and zero after reset until a fault
// - supply undervoltage bit 7, overvoltage bit 6, charge pump undervoltage bit 5
// - overtemperature warning bit 4, shutdown bit 3, separate, reset zero
// - watchdog fault sets bit 2 of the supply register
// - frame fault bit 1 set when a frame has other than sixteen clocks
// - frame fault stays out of fault pin and global fault indicator
// - variant register holds id in bits 3-0, bits 7-4 read zero
// - serial ok reads zero from a frame fault until a fault clear, one otherwise
// - bridge summary is the OR of all overcurrent and gate faults
// - thermal summary is OR of warnings, shutdown, watchdog and other warnings
module gfs_status_bank
  import gfs_pkg::*;
#(
  parameter logic [3:0] VariantId = 4'h5   // arbitrary neutral value
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // fault indications from the detectors
  input  wire logic [15:0] gateFaultIn,
  input  wire logic [15:0] overcurrentFaultIn,
  input  wire logic        supplyUvIn,
  input  wire logic        supplyOvIn,
  input  wire logic        chargePumpUvIn,
  input  wire logic        overTempWarnIn,
  input  wire logic        overTempShdnIn,
  input  wire logic        watchdogFaultIn,
  input  wire logic        otherWarnIn,
  input  wire logic        clearFault,
  // serial frame observation
  input  wire logic        frameActive,
  input  wire logic        serialClockRise,
  // register read port
  input  wire logic        readStrobe,
  input  wire logic        writeStrobe,
  input  wire logic [5:0]  regAddr,
  output logic [7:0]       readData,
  output logic             readHit,
  // summaries
  output logic             serialOk,
  output logic             bridgeFaultSummary,
  output logic             thermalWatchdogSummary,
  output logic             faultOutputPin_n
);

  // ==========================================================
  // latched status
  logic [7:0] gateFaultStatusLow;
  logic [7:0] gateFaultStatusHigh;
  logic [7:0] supplyTempLinkStatus;
  logic [3:0] deviceVariantField;
  logic       frameFaultPulse;
  logic [7:0] next_readData;

  gfs_frame_checker u_frame_checker (
    .core_clk        (core_clk),
    .reset           (reset),
    .frameActive     (frameActive),
    .serialClockRise (serialClockRise),
    .frameFaultPulse (frameFaultPulse)
  );

  // set wins over clear so an event in the clearing cycle survives
  function automatic logic [7:0] latchBits(input logic [7:0] cur, input logic [7:0] set,
                                           input logic clr);
    latchBits = (clr ? 8'h00 : cur) | set;
  endfunction : latchBits

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gateFaultStatusLow  <= StatusResetValue;
      gateFaultStatusHigh <= StatusResetValue;
    end else begin
      gateFaultStatusLow  <= latchBits(gateFaultStatusLow, gateFaultIn[15:8], clearFault);
      gateFaultStatusHigh <= latchBits(gateFaultStatusHigh, gateFaultIn[7:0], clearFault);
    end
  end

  logic [7:0] supplySet;
  always_comb begin
    supplySet                  = 8'h00;
    supplySet[SupplyUvBit]     = supplyUvIn;
    supplySet[SupplyOvBit]     = supplyOvIn;
    supplySet[ChargePumpUvBit] = chargePumpUvIn;
    supplySet[OverTempWarnBit] = overTempWarnIn;
    supplySet[OverTempShdnBit] = overTempShdnIn;
    supplySet[WatchdogBit]     = watchdogFaultIn;
    supplySet[SerialFrameBit]  = frameFaultPulse;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      supplyTempLinkStatus <= StatusResetValue;
    end else begin
      supplyTempLinkStatus <= latchBits(supplyTempLinkStatus, supplySet, clearFault);
    end
  end

  // strap-like identity captured after reset release, never during reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      deviceVariantField <= VariantResetField;
    end else begin
      deviceVariantField <= VariantId;
    end
  end

  // ==========================================================
  // summaries; frame fault deliberately excluded from the pin
  logic otherWarnLatched;
  logic overcurrentAny;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      otherWarnLatched <= 1'b0;
      overcurrentAny   <= 1'b0;
    end else begin
      otherWarnLatched <= (clearFault ? 1'b0 : otherWarnLatched) | otherWarnIn;
      overcurrentAny   <= (clearFault ? 1'b0 : overcurrentAny) | (|overcurrentFaultIn);
    end
  end

  assign serialOk               = ~supplyTempLinkStatus[SerialFrameBit];
  assign bridgeFaultSummary     = overcurrentAny | (|gateFaultStatusLow)
                                  | (|gateFaultStatusHigh);
  assign thermalWatchdogSummary = supplyTempLinkStatus[OverTempWarnBit]
                                  | supplyTempLinkStatus[OverTempShdnBit]
                                  | supplyTempLinkStatus[WatchdogBit] | otherWarnLatched;
  assign faultOutputPin_n       = ~(bridgeFaultSummary | supplyTempLinkStatus[SupplyUvBit]
                                  | supplyTempLinkStatus[SupplyOvBit]
                                  | supplyTempLinkStatus[ChargePumpUvBit]
                                  | supplyTempLinkStatus[OverTempShdnBit]
                                  | supplyTempLinkStatus[WatchdogBit]);

  // ==========================================================
  // read port; writes change no register, a write strobe only blocks the read
  always_comb begin
    next_readData = 8'h00;
    unique case (regAddr)
      GateFaultStatusLowAddr:  next_readData = gateFaultStatusLow;
      GateFaultStatusHighAddr: next_readData = gateFaultStatusHigh;
      SupplyTempLinkAddr:      next_readData = supplyTempLinkStatus;
      VariantIdentityAddr:     next_readData = {4'h0, deviceVariantField};
      default:                 next_readData = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      readData <= 8'h00;
      readHit  <= 1'b0;
    end else begin
      readHit <= readStrobe && !writeStrobe;
      if (readStrobe && !writeStrobe) begin
        readData <= next_readData;
      end
    end
  end

  // ==========================================================
  // assertions
  property p_gate_latch;
    @(posedge core_clk) disable iff (reset)
      (gateFaultIn[15] && !reset) |=> gateFaultStatusLow[7];
  endproperty
  a_gate_latch: assert property (p_gate_latch) else $error("high side one not latched");

  property p_gate_high;
    @(posedge core_clk) disable iff (reset) gateFaultIn[0] |=> gateFaultStatusHigh[0];
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("low side eight not latched");

  property p_reset_zero;
    @(posedge core_clk) reset |=> (gateFaultStatusLow == 8'h00 && gateFaultStatusHigh == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("gate bits not zero after reset");

  property p_hold;
    @(posedge core_clk) disable iff (reset)
      (!clearFault && supplyTempLinkStatus[SupplyUvBit]) |=> supplyTempLinkStatus[SupplyUvBit];
  endproperty
  a_hold: assert property (p_hold) else $error("latched fault dropped without clear");

  property p_frame_no_pin;
    @(posedge core_clk) disable iff (reset)
      $rose(supplyTempLinkStatus[SerialFrameBit]) && $stable(supplyTempLinkStatus[7:2])
      && $stable(bridgeFaultSummary) |-> $stable(faultOutputPin_n);
  endproperty
  a_frame_no_pin: assert property (p_frame_no_pin) else $error("frame fault drove pin");

  property p_serial_ok;
    @(posedge core_clk) disable iff (reset) frameFaultPulse |=> !serialOk;
  endproperty
  a_serial_ok: assert property (p_serial_ok) else $error("serial ok stayed high");

  property p_wd;
    @(posedge core_clk) disable iff (reset) watchdogFaultIn |=> thermalWatchdogSummary;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog not in summary");

  property p_variant_read;
    @(posedge core_clk) disable iff (reset)
      (readStrobe && !writeStrobe && regAddr == VariantIdentityAddr)
      |=> readData[7:4] == 4'h0;
  endproperty
  a_variant_read: assert property (p_variant_read) else $error("reserved bits nonzero");

  property p_read_still;
    @(posedge core_clk) disable iff (reset)
      (readStrobe && !clearFault && !(|supplySet)) |=> $stable(supplyTempLinkStatus);
  endproperty
  a_read_still: assert property (p_read_still) else $error("read altered status");

  c_clear: cover property (@(posedge core_clk) disable iff (reset)
    clearFault && (|gateFaultStatusLow));
  c_read_supply: cover property (@(posedge core_clk) disable iff (reset)
    readStrobe && regAddr == SupplyTempLinkAddr);
  c_pin_low: cover property (@(posedge core_clk) disable iff (reset) !faultOutputPin_n);

endmodule : gfs_status_bank

// ===== verification/gfs_host_model.sv
// host model: issues serial frames, each carrying one register access
module gfs_host_model
  import gfs_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // command from the bench
  input  wire logic       go,
  input  wire logic       doWrite,
  input  wire logic [5:0] addr,
  input  wire logic [4:0] pulses,
  // serial side towards the bank
  output logic            frameActive,
  output logic            serialClockRise,
  output logic            readStrobe,
  output logic            writeStrobe,
  output logic [5:0]      regAddr,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // frame sequencer
  initial begin
    {frameActive, serialClockRise, readStrobe, writeStrobe, busy} = '0;
    regAddr = 6'h2A;
    forever begin
      @(posedge core_clk);
      if (go && !reset) begin
        busy <= 1'b1;
        frameActive <= 1'b1;
        repeat (pulses) begin
          @(posedge core_clk);
          serialClockRise <= 1'b1;
        end
        @(posedge core_clk);
        serialClockRise <= 1'b0;
        frameActive <= 1'b0;
        readStrobe <= !doWrite;
        writeStrobe <= doWrite;
        regAddr <= addr;
        @(posedge core_clk);
        {readStrobe, writeStrobe, busy} <= '0;
        // released address does not keep its last value
        regAddr <= ~addr;
      end
    end
  end
endmodule : gfs_host_model

// ===== verification/tb_top.sv
// testbench: scoreboard driven checks of the gate fault status bank
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gfs_pkg::*;
  localparam logic [3:0] Vid = 4'h9;  // arbitrary value
  logic core_clk = 0, reset = 1, go = 0, doWrite = 0, clearFault = 0;
  logic [5:0] addr = '0, regAddr;
  logic [4:0] pulses = 5'h10;
  logic [15:0] gateF = '0, ocF = '0;
  logic [6:0] sup = '0;
  logic frameActive, serialClockRise, readStrobe, writeStrobe, busy;
  logic [7:0] readData;
  logic readHit, serialOk, bSum, tSum, pin_n;
  logic [7:0] expQ[$];
  int fails = 0, cmp_count = 0;
  logic [31:0] seed = 32'd55;
  initial forever #25 core_clk = ~core_clk;
  gfs_host_model i_host (.core_clk(core_clk), .reset(reset), .go(go), .doWrite(doWrite),
    .addr(addr), .pulses(pulses), .frameActive(frameActive),
    .serialClockRise(serialClockRise), .readStrobe(readStrobe),
    .writeStrobe(writeStrobe), .regAddr(regAddr), .busy(busy));
  gfs_status_bank #(.VariantId(Vid)) i_dut (.core_clk(core_clk), .reset(reset),
    .gateFaultIn(gateF), .overcurrentFaultIn(ocF), .supplyUvIn(sup[6]),
    .supplyOvIn(sup[5]), .chargePumpUvIn(sup[4]), .overTempWarnIn(sup[3]),
    .overTempShdnIn(sup[2]), .watchdogFaultIn(sup[1]), .otherWarnIn(sup[0]),
    .clearFault(clearFault), .frameActive(frameActive),
    .serialClockRise(serialClockRise), .readStrobe(readStrobe),
    .writeStrobe(writeStrobe), .regAddr(regAddr), .readData(readData), .readHit(readHit),
    .serialOk(serialOk), .bridgeFaultSummary(bSum), .thermalWatchdogSummary(tSum),
    .faultOutputPin_n(pin_n));
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic xfer(input logic w, input logic [5:0] a, input logic [4:0] n,
                      input logic [7:0] e);
    int k;
    @(posedge core_clk);
    go <= 1'b1; doWrite <= w; addr <= a; pulses <= n;
    if (!w) expQ.push_back(e);
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    k = 0;
    while (busy !== 1'b0 && k < 40) begin
      @(posedge core_clk);
      k++;
    end
    // a host that never finishes its frame counts as a mismatch
    if (k >= 40) fails++;
    repeat (3) @(posedge core_clk);
  endtask : xfer
  task automatic clr();
    @(posedge core_clk);
    {gateF, ocF, sup} <= '0;
    clearFault <= 1'b1;
    @(posedge core_clk);
    clearFault <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : clr
  task automatic pulse(input logic [15:0] g, input logic [15:0] o, input logic [6:0] s);
    @(posedge core_clk);
    gateF <= g; ocF <= o; sup <= s;
    @(posedge core_clk);
    {gateF, ocF, sup} <= '0;  // removed at once: bits must stay latched
    repeat (3) @(posedge core_clk);
  endtask : pulse
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // ==========================================================
  // scoreboard: each read answer against the oldest note
  always @(posedge core_clk) begin
    logic [7:0] expV;
    if (readHit === 1'b1) begin
      if (expQ.size() == 0) `CHK(readHit, 1'b0)
      else begin
        // pop once: the compare macro reads its arguments twice
        expV = expQ.pop_front();
        `CHK(readData, expV)
      end
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    conclude();
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [15:0] r;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int a = 3; a < 6; a++) xfer(0, 6'(a), 16, 8'h00);
    xfer(0, VariantIdentityAddr, 16, {4'h0, Vid});
    xfer(0, 6'h07, 16, 8'h00);
    `CHK({serialOk, pin_n, bSum, tSum}, 4'b1100)
    for (int i = 0; i < 3; i++) begin
      r = 16'(rnd()) | 16'h0001;
      pulse(r, '0, '0);
      `CHK(bSum, 1'b1)
      `CHK(pin_n, 1'b0)
      xfer(1, GateFaultStatusLowAddr, 16, 8'h00);
      xfer(0, GateFaultStatusLowAddr, 16, r[15:8]);
      xfer(0, GateFaultStatusLowAddr, 16, r[15:8]);
      xfer(0, GateFaultStatusHighAddr, 16, r[7:0]);
      clr();
      `CHK(bSum, 1'b0)
    end
    // reset in mid-run must wipe every latched bit
    pulse(16'hFFFF, 16'hFFFF, 7'h7F);
    reset <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    `CHK({serialOk, pin_n, bSum, tSum}, 4'b1100)
    xfer(0, GateFaultStatusLowAddr, 16, 8'h00);
    xfer(0, GateFaultStatusHighAddr, 16, 8'h00);
    xfer(0, SupplyTempLinkAddr, 16, 8'h00);
    pulse('0, 16'(rnd()) | 16'h8000, '0);
    `CHK(bSum, 1'b1)
    xfer(0, GateFaultStatusHighAddr, 16, 8'h00);
    clr();
    for (int i = 0; i < 7; i++) begin
      pulse('0, '0, 7'h40 >> i);
      `CHK(tSum, 1'(i >= 3))
      `CHK(pin_n, 1'(i == 3 || i == 6))
      xfer(1, SupplyTempLinkAddr, 16, 8'h00);
      xfer(0, SupplyTempLinkAddr, 16, (i < 6) ? (8'h80 >> i) : 8'h00);
      clr();
    end
    for (int j = 0; j < 5; j++) begin
      xfer(1, SupplyTempLinkAddr, 5'(15 + 2 * (j % 2)), 8'h00);
      `CHK({serialOk, pin_n}, 2'b01)
      xfer(0, SupplyTempLinkAddr, 16, 8'h02);
      clr();
      xfer(0, SupplyTempLinkAddr, 16, 8'h00);
      `CHK(serialOk, 1'b1)
    end
    repeat (4) @(posedge core_clk);
    `CHK(expQ.size(), 0)
    conclude();
  end
endmodule : tb_top
